// >>> include/asr_interp_if.sv
`timescale 1ns/1ps
interface asr_interp_if;
	import asr_pkg::*;
	logic start;
	asr_pair_s older;
	asr_pair_s newer;
	logic [15:0] elapsed;
	logic [15:0] period;
	logic done;
	asr_pair_s held;
	modport ctl (output start, older, newer, elapsed, period, input done, held);
	modport eng (input start, older, newer, elapsed, period, output done, held);
endinterface

// >>> include/asr_map.svh
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Register byte offsets, decoded from haddr[7:0]
`define ASR_OFS_CTRL 8'h00
`define ASR_OFS_STATUS 8'h04
`define ASR_OFS_IN_PERIOD 8'h08
`define ASR_OFS_W 8

// Control register fields
`define ASR_CTRL_W 3
`define ASR_CTRL_MUTE 0
`define ASR_CTRL_PD 1
`define ASR_CTRL_FOLLOW 2
`define ASR_CTRL_RST 3'h4

// Sample FIFO
`define ASR_FIFO_DEPTH 8
`define ASR_IDX_W 3
`define ASR_PTR_W 4
`define ASR_FILL_MIN 4'h2
`define ASR_FILL_MAX 4'h6
`define ASR_LAG 4'h4

// Rate tracking: period estimate in clk cycles with fraction bits
`define ASR_EST_W 28
`define ASR_EST_FRAC 12
`define ASR_EST_ONE 28'h0001000
`define ASR_SHIFT_SLOW 12
`define ASR_SHIFT_FAST 10
`define ASR_CNT_MAX 16'hffff

// Times and rates
`define ASR_CLK_KHZ 250000
`define ASR_SETTLE_SLOW_MS 800
`define ASR_SETTLE_FAST_MS 200
`define ASR_RATE_MIN_HZ 8000
`define ASR_RATE_MAX_HZ 56000
`define ASR_PER_MAX 16'((`ASR_CLK_KHZ * 1000) / `ASR_RATE_MIN_HZ)
`define ASR_PER_MIN 16'((`ASR_CLK_KHZ * 1000) / `ASR_RATE_MAX_HZ)

// Fine time grid: 65536 phases per input period
`define ASR_UPSAMPLE_FACTOR 65536
`define ASR_FRAC_W 16
`define ASR_DIV_LAST 4'hf
`define ASR_GRID_KHZ 3276800
`define ASR_GRID_PS 300

`endif

// >>> include/asr_pkg.sv
package asr_pkg;

	typedef logic [15:0] asr_samp_t;

	typedef struct packed {
		asr_samp_t l;
		asr_samp_t r;
	} asr_pair_s;

	typedef enum logic [1:0] {ASR_IDLE, ASR_DIV, ASR_MAC} asr_eng_e;

endpackage

// >>> rtl/asr_core.sv
`timescale 1ns/1ps
`include "asr_map.svh"
// Summary of operation
// - Reset holds all logic idle
// - Mute status high while FIFO pointers overlap
// - Mute request forces output samples to zero
// - Select high: slow settling, about 800 ms
// - Select low: fast settling, about 200 ms
// - Settle select synchronised, may change anytime
// - Power-down request stops activity, low dissipation
// - 250 MHz clock, 8 to 56 kHz rates
// - External clock replaces oscillator as master clock
// - Conceptual upsampling with zero stuffing before filtering
// - Interpolation ratio is 65536 phases
// - Interpolation kernel band-limits before resampling
// - Held result register is the zero-order hold
// - Fine grid about 300 ps, 3.2768 GHz
// - Polyphase phase select instead of direct convolution
// - Write pointer advanced by input frame clock
// - Settle select switches servo loop filter coefficients
// - Frame clocks synchronised before rate tracking
module asr_core #(
	parameter int SETTLE_SLOW_CYC = `ASR_SETTLE_SLOW_MS * `ASR_CLK_KHZ, // Slow settle window
	parameter int SETTLE_FAST_CYC = `ASR_SETTLE_FAST_MS * `ASR_CLK_KHZ // Fast settle window
) (
	input wire logic clk, // Master clock
	input wire logic rst, // Async reset, active high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, words only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic input_frame_clock, // Input sample clock
	input wire logic output_frame_clock, // Output sample clock
	input wire logic slow_settle_select, // Async settle mode select
	input wire asr_pkg::asr_pair_s in_sample, // Stereo input sample
	output asr_pkg::asr_pair_s out_sample, // Stereo output sample
	output logic out_valid, // Output sample strobe
	output logic mute_status // FIFO pointer overlap
);
	import asr_pkg::*;

	typedef struct packed {
		logic fi_d;
		logic fo_d;
		logic sel_d;
		logic [`ASR_PTR_W-1:0] wptr;
		logic [`ASR_PTR_W-1:0] rptr;
		asr_pair_s [`ASR_FIFO_DEPTH-1:0] fifo;
		logic [15:0] cnt_in;
		logic [`ASR_EST_W-1:0] est_in;
		logic [`ASR_EST_W-1:0] vph;
		logic [27:0] settle;
		logic [`ASR_CTRL_W-1:0] ctrl;
		logic mute_status;
		logic start;
		logic busy;
		asr_pair_s out_sample;
		logic out_valid;
		logic pend;
		logic [`ASR_OFS_W-1:0] a_ofs;
		logic a_wr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic hresp;
	} asr_core_s;

	localparam logic [27:0] SLOW_CYC = 28'(SETTLE_SLOW_CYC);
	localparam logic [27:0] FAST_CYC = 28'(SETTLE_FAST_CYC);

	asr_core_s st, next_st;
	logic [2:0] sync_q;
	logic fi, fo, sel;
	logic fi_evt, fo_evt, pd, muted, accept, fill_bad, rate_ok;
	logic [`ASR_PTR_W-1:0] fill;
	logic [15:0] meas;
	logic signed [`ASR_EST_W:0] diff;
	logic signed [`ASR_EST_W:0] step;
	logic [31:0] rdata;

	asr_interp_if u_if();

	// clk is the master clock whether from the crystal or an external source
	asr_sync #(.N(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({slow_settle_select, output_frame_clock, input_frame_clock}),
		.sync_out(sync_q)
	);

	asr_interp u_interp (
		.clk(clk),
		.rst(rst),
		.bus(u_if.eng)
	);

	// Frame clocks and select only used after the synchroniser
	assign fi = sync_q[0];
	assign fo = sync_q[1];
	assign sel = sync_q[2];
	assign fi_evt = fi & ~st.fi_d;
	assign fo_evt = fo & ~st.fo_d;
	assign pd = st.ctrl[`ASR_CTRL_PD];
	// Automatic muting when mute status is looped back
	assign muted = st.ctrl[`ASR_CTRL_MUTE] | (st.ctrl[`ASR_CTRL_FOLLOW] & st.mute_status);
	assign fill = st.wptr - st.rptr;
	assign fill_bad = (fill < `ASR_FILL_MIN) || (fill > `ASR_FILL_MAX);
	assign accept = hsel & hready & htrans[1];
	assign rate_ok = (st.est_in[`ASR_EST_W-1:`ASR_EST_FRAC] >= `ASR_PER_MIN) &&
		(st.est_in[`ASR_EST_W-1:`ASR_EST_FRAC] <= `ASR_PER_MAX);

	// Servo loop: first-order low pass on the measured input period
	assign meas = (st.cnt_in == `ASR_CNT_MAX) ? st.cnt_in : st.cnt_in + 16'h1;
	assign diff = $signed({1'b0, meas, `ASR_EST_FRAC'(0)}) - $signed({1'b0, st.est_in});
	// Longer time constant in slow mode rejects more jitter
	assign step = sel ? (diff >>> `ASR_SHIFT_SLOW) : (diff >>> `ASR_SHIFT_FAST);

	// Phase request to the interpolator reads the FIFO at the virtual read point
	assign u_if.start = st.start;
	assign u_if.newer = st.fifo[st.rptr[`ASR_IDX_W-1:0]];
	assign u_if.older = st.fifo[st.rptr[`ASR_IDX_W-1:0] - `ASR_IDX_W'(1)];
	assign u_if.elapsed = st.vph[`ASR_EST_W-1:`ASR_EST_FRAC];
	assign u_if.period = st.est_in[`ASR_EST_W-1:`ASR_EST_FRAC];

	always_comb begin
		case (st.a_ofs)
			`ASR_OFS_CTRL: rdata = {29'h0, st.ctrl};
			`ASR_OFS_STATUS: rdata = {24'h0, fill, rate_ok, sel, st.settle == '0,
				st.mute_status};
			`ASR_OFS_IN_PERIOD: rdata = {16'h0, st.est_in[`ASR_EST_W-1:`ASR_EST_FRAC]};
			default: rdata = 32'h0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.out_valid = 1'b0;
		next_st.fi_d = fi;
		next_st.fo_d = fo;
		next_st.sel_d = sel;

		// A mode change restarts the settling window
		if (sel != st.sel_d) begin
			next_st.settle = sel ? SLOW_CYC : FAST_CYC;
		end else if (st.settle != '0) begin
			next_st.settle = st.settle - 28'h1;
		end

		if (!pd) begin
			next_st.cnt_in = meas;
			if (fi_evt) begin
				// Input samples written at the input frame rate
				next_st.fifo[st.wptr[`ASR_IDX_W-1:0]] = in_sample;
				next_st.wptr = st.wptr + `ASR_PTR_W'(1);
				next_st.cnt_in = 16'h0;
				if (st.cnt_in == `ASR_CNT_MAX) begin
					// First edge after reset or a stalled source: no whole period seen
					next_st.est_in = st.est_in;
				end else if (st.est_in == '0) begin
					next_st.est_in = {meas, `ASR_EST_FRAC'(0)};
				end else begin
					next_st.est_in = st.est_in + step[`ASR_EST_W-1:0];
				end
			end

			// Read side follows the filtered period, not the raw edges, so jitter
			// on the frame clocks does not reach the read point
			if ((st.est_in != '0) && (st.vph + `ASR_EST_ONE >= st.est_in)) begin
				next_st.vph = st.vph + `ASR_EST_ONE - st.est_in;
				next_st.rptr = st.rptr + `ASR_PTR_W'(1);
			end else begin
				next_st.vph = st.vph + `ASR_EST_ONE;
			end

			if (fo_evt) begin
				// Overlap marks the data invalid and re-centres the read point
				next_st.mute_status = fill_bad;
				if (fill_bad) begin
					next_st.rptr = st.wptr - `ASR_LAG;
					next_st.vph = '0;
				end
				// An output event during a running phase is dropped; the engine
				// needs 18 cycles against thousands between frames
				if (!st.busy) begin
					next_st.start = 1'b1;
					next_st.busy = 1'b1;
				end
			end
		end else begin
			next_st.out_sample = '0;
		end

		if (u_if.done) begin
			next_st.busy = 1'b0;
			next_st.out_sample = (muted | pd) ? '0 : u_if.held;
			next_st.out_valid = ~pd;
		end

		// AHB-Lite slave with one wait state per transfer
		if (st.pend) begin
			next_st.pend = 1'b0;
			next_st.hreadyout = 1'b1;
			if (st.a_wr) begin
				if (st.a_ofs == `ASR_OFS_CTRL) begin
					next_st.ctrl = hwdata[`ASR_CTRL_W-1:0];
				end
			end else begin
				next_st.hrdata = rdata;
			end
		end else if (accept) begin
			next_st.pend = 1'b1;
			next_st.a_ofs = haddr[`ASR_OFS_W-1:0];
			next_st.a_wr = hwrite;
			next_st.hreadyout = 1'b0;
		end
	end

	// Pointers and loop state cleared, mute held until the pointers separate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.ctrl <= `ASR_CTRL_RST;
			st.mute_status <= 1'b1;
			st.cnt_in <= `ASR_CNT_MAX;
			st.hreadyout <= 1'b1;
			st.settle <= FAST_CYC;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.hrdata;
	assign hreadyout = st.hreadyout;
	assign hresp = st.hresp;
	assign out_sample = st.out_sample;
	assign out_valid = st.out_valid;
	assign mute_status = st.mute_status;

	chk_mute_zero: assert property (@(posedge clk) disable iff (rst)
		(st.out_valid && $past(st.ctrl[`ASR_CTRL_MUTE])) |-> (st.out_sample == '0))
		else $error("muted output sample is not zero");

	chk_mute_overlap: assert property (@(posedge clk) disable iff (rst)
		(fo_evt && !pd) |=> (st.mute_status == $past(fill_bad)))
		else $error("mute status does not follow pointer overlap");

	chk_mute_stable: assert property (@(posedge clk) disable iff (rst)
		!(fo_evt && !pd) |=> $stable(st.mute_status))
		else $error("mute status changed without an output event");

	chk_pd_quiet: assert property (@(posedge clk) disable iff (rst)
		pd |=> (!st.out_valid && st.out_sample == '0))
		else $error("activity on output during power-down");

	chk_wptr_step: assert property (@(posedge clk) disable iff (rst)
		(fi_evt && !pd) |=> (st.wptr == $past(st.wptr) + `ASR_PTR_W'(1)))
		else $error("write pointer did not advance on input frame");

	chk_sync_edge: assert property (@(posedge clk) disable iff (rst)
		fi_evt |-> ($past(input_frame_clock, 2) && !$past(input_frame_clock, 3)))
		else $error("input frame event not two cycles after pin edge");

	chk_settle_load: assert property (@(posedge clk) disable iff (rst)
		(sel != st.sel_d) |=> (st.settle == ($past(sel) ? SLOW_CYC : FAST_CYC)))
		else $error("settle window not reloaded on mode change");

	chk_bus_wait: assert property (@(posedge clk) disable iff (rst)
		(accept && !st.pend) |=> !st.hreadyout ##1 st.hreadyout)
		else $error("bus transfer not answered after one wait state");

	chk_ctrl_write: assert property (@(posedge clk) disable iff (rst)
		(st.pend && st.a_wr && st.a_ofs == `ASR_OFS_CTRL) |=>
		(st.ctrl == $past(hwdata[`ASR_CTRL_W-1:0])))
		else $error("control write not applied");

	chk_unmuted_pass: assert property (@(posedge clk) disable iff (rst)
		(st.out_valid && !$past(muted) && !$past(pd)) |-> (st.out_sample == $past(u_if.held)))
		else $error("unmuted output sample differs from held result");

	chk_recentre_read: assert property (@(posedge clk) disable iff (rst)
		(fo_evt && !pd && fill_bad) |=> (st.rptr == $past(st.wptr) - `ASR_LAG))
		else $error("read point not re-centred after pointer overlap");

	chk_pd_frozen: assert property (@(posedge clk) disable iff (rst)
		pd |=> ($stable(st.wptr) && $stable(st.rptr)))
		else $error("FIFO pointers moved during power-down");

	chk_settle_count: assert property (@(posedge clk) disable iff (rst)
		(sel == st.sel_d && st.settle != '0) |=> (st.settle == $past(st.settle) - 28'h1))
		else $error("settle window did not count down");

	chk_out_pulse: assert property (@(posedge clk) disable iff (rst)
		st.out_valid |=> !st.out_valid)
		else $error("output strobe longer than one cycle");
endmodule

// >>> rtl/asr_interp.sv
`timescale 1ns/1ps
`include "asr_map.svh"
module asr_interp (
	input wire logic clk, // Master clock
	input wire logic rst, // Async reset, active high
	asr_interp_if.eng bus // Phase request and held result
);
	import asr_pkg::*;

	typedef struct packed {
		asr_eng_e eng;
		logic [3:0] cnt;
		logic [15:0] rem;
		logic [15:0] per;
		logic [`ASR_FRAC_W-1:0] quo;
		asr_pair_s older;
		asr_pair_s newer;
		asr_pair_s held;
		logic done;
	} asr_interp_s;

	asr_interp_s st, next_st;
	logic [16:0] trial;

	// Weighted blend of the two neighbouring coarse samples by the fine phase
	function automatic asr_samp_t blend(input asr_samp_t a, input asr_samp_t b,
		input logic [`ASR_FRAC_W-1:0] f);
		logic signed [16:0] d;
		logic signed [33:0] p;
		logic signed [17:0] s;
		d = $signed({b[15], b}) - $signed({a[15], a});
		p = d * $signed({1'b0, f});
		s = $signed({{2{a[15]}}, a}) + p[33:16];
		return s[15:0];
	endfunction

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		trial = {st.rem, 1'b0};
		case (st.eng)
			ASR_IDLE: begin
				if (bus.start) begin
					next_st.eng = ASR_DIV;
					next_st.cnt = 4'h0;
					next_st.quo = '0;
					next_st.per = bus.period;
					next_st.older = bus.older;
					next_st.newer = bus.newer;
					// Phase past the period is clamped to the last phase
					next_st.rem = (bus.elapsed >= bus.period) ? bus.period - 16'h1 : bus.elapsed;
				end
			end
			ASR_DIV: begin
				// One quotient bit a cycle selects one of 65536 phases
				if (trial >= {1'b0, st.per}) begin
					next_st.rem = 16'(trial - {1'b0, st.per});
					next_st.quo = {st.quo[`ASR_FRAC_W-2:0], 1'b1};
				end else begin
					next_st.rem = trial[15:0];
					next_st.quo = {st.quo[`ASR_FRAC_W-2:0], 1'b0};
				end
				next_st.cnt = st.cnt + 4'h1;
				if (st.cnt == `ASR_DIV_LAST) begin
					next_st.eng = ASR_MAC;
				end
			end
			ASR_MAC: begin
				// Only the selected phase is evaluated, never the full dense kernel
				next_st.held.l = blend(st.older.l, st.newer.l, st.quo);
				next_st.held.r = blend(st.older.r, st.newer.r, st.quo);
				next_st.done = 1'b1;
				next_st.eng = ASR_IDLE;
			end
			default: begin
				next_st.eng = ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Result register is the zero-order hold
	assign bus.held = st.held;
	assign bus.done = st.done;

	chk_phase_latency: assert property (@(posedge clk) disable iff (rst)
		(bus.start && st.eng == ASR_IDLE) |-> ##18 st.done)
		else $error("phase result not ready 18 cycles after start");

	chk_zoh_hold: assert property (@(posedge clk) disable iff (rst)
		$changed(st.held) |-> st.done)
		else $error("held sample changed outside a result cycle");
endmodule

// >>> rtl/asr_sync.sv
`timescale 1ns/1ps
module asr_sync #(
	parameter int N = 3 // Number of bits
) (
	input wire logic clk, // Master clock
	input wire logic rst, // Async reset, active high
	input wire logic [N-1:0] async_in, // Unsynchronised levels
	output logic [N-1:0] sync_out // Synchronised levels
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
	} asr_sync_s;

	asr_sync_s st, next_st;

	always_comb begin
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.s2;
endmodule

// >>> test/asr_audio_model.sv
`timescale 1ns/1ps
module asr_audio_model #(
	parameter int IN_PER = 4500, // Input frame period in clk cycles
	parameter int OUT_PER = 4600 // Output frame period in clk cycles
) (
	input wire logic clk, // Master clock
	input wire logic rst, // Async reset, active high
	input wire logic in_run, // Input frames running
	input wire logic [31:0] level, // Stereo sample value to send
	output logic input_frame_clock, // Input sample clock
	output logic output_frame_clock, // Output sample clock
	output logic [31:0] in_sample // Stereo input sample
);
	int ci;
	int co;
	// Sample held steady for the whole frame, so capture timing never matters
	assign in_sample = level;
	// Both periods sit inside the 8 to 56 kHz span at 250 MHz, half high, half low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ci <= 0;
			co <= 0;
			input_frame_clock <= 1'b0;
			output_frame_clock <= 1'b0;
		end else begin
			co <= (co == OUT_PER - 1) ? 0 : co + 1;
			output_frame_clock <= (co < OUT_PER / 2);
			// A stopped source parks its clock low, which starves the FIFO
			if (in_run) begin
				ci <= (ci == IN_PER - 1) ? 0 : ci + 1;
				input_frame_clock <= (ci < IN_PER / 2);
			end else begin
				input_frame_clock <= 1'b0;
			end
		end
	end
endmodule

// >>> test/async_rate_converter_control_tb.sv
`timescale 1ns/1ps
module async_rate_converter_control_tb;
	import asr_pkg::*;
	logic clk;
	logic rst;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic ifc;
	logic ofc;
	logic sel;
	logic in_run;
	logic [31:0] level;
	logic [31:0] in_sample;
	asr_pair_s out_sample;
	logic out_valid;
	logic mute_status;
	logic [31:0] q;
	logic [31:0] v;
	logic [31:0] smp_q[$];
	int n_fail;
	int comparisons;
	int seed;
	int n_ov;
	int snap;

	asr_core #(.SETTLE_SLOW_CYC(200), .SETTLE_FAST_CYC(50)) uut (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.input_frame_clock(ifc), .output_frame_clock(ofc),
		.slow_settle_select(sel), .in_sample(in_sample), .out_sample(out_sample),
		.out_valid(out_valid), .mute_status(mute_status)
	);

	asr_audio_model model (
		.clk(clk), .rst(rst), .in_run(in_run), .level(level),
		.input_frame_clock(ifc), .output_frame_clock(ofc), .in_sample(in_sample)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Called just after a rising edge; ready and read data are the values that edge samples
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
		check(32'(hresp), 32'h0);
	endtask

	task automatic expect_out(input int n, input logic [31:0] e);
		repeat (n) begin
			@(posedge ofc);
			smp_q.push_back(e);
		end
		repeat (40) @(posedge clk);
		check(32'(smp_q.size()), 32'h0);
	endtask

	always @(negedge clk) begin
		if (out_valid === 1'b1) begin
			n_ov++;
			if (smp_q.size() > 0) begin
				check(out_sample, smp_q.pop_front());
			end
		end
	end

	initial begin
		#396000;
		n_fail++;
		print_verdict();
	end

	initial begin
		seed = 32'hb1d90440;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		sel = 1'b0;
		in_run = 1'b0;
		level = $random(seed);
		repeat (12) @(posedge clk);
		check(32'(hreadyout), 32'h1);
		check(32'(out_valid), 32'h0);
		check(32'(mute_status), 32'h1);
		rst <= 1'b0;
		ahb(1'b0, 8'h00, 32'h0, q);
		check(q, 32'h4);
		v = $random(seed);
		ahb(1'b1, 8'h00, v, q);
		ahb(1'b0, 8'h00, 32'h0, q);
		check(q, {29'h0, v[2:0]});
		ahb(1'b1, 8'h08, v, q);
		ahb(1'b0, 8'h08, 32'h0, q);
		check(q, 32'h0);
		ahb(1'b0, 8'h0c, 32'h0, q);
		check(q, 32'h0);
		$display("registers done");
		// Slow then fast: the sel status bit and the settle window length tell the two modes apart
		for (int m = 1; m >= 0; m--) begin
			sel <= m[0];
			repeat (5) @(posedge clk);
			ahb(1'b0, 8'h04, 32'h0, q);
			check(q & 32'h6, {29'h0, m[0], 2'h0});
			repeat ((m == 1 ? 200 : 50) - 30) @(posedge clk);
			ahb(1'b0, 8'h04, 32'h0, q);
			check(q & 32'h2, 32'h0);
			repeat (40) @(posedge clk);
			ahb(1'b0, 8'h04, 32'h0, q);
			check(q & 32'h2, 32'h2);
		end
		$display("settling done");
		ahb(1'b1, 8'h00, 32'h0, q);
		in_run <= 1'b1;
		repeat (6) @(posedge ifc);
		expect_out(2, level);
		check(32'(mute_status), 32'h0);
		ahb(1'b1, 8'h00, 32'h1, q);
		expect_out(2, 32'h0);
		// Loopback on: a healthy FIFO must still pass the samples through
		ahb(1'b1, 8'h00, 32'h4, q);
		expect_out(1, level);
		$display("streaming done");
		in_run <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge out_valid);
			@(negedge clk);
			if (mute_status === 1'b1) begin
				break;
			end
		end
		check(32'(mute_status), 32'h1);
		check(out_sample, 32'h0);
		in_run <= 1'b1;
		$display("overlap done");
		@(posedge clk);
		ahb(1'b1, 8'h00, 32'h2, q);
		snap = n_ov;
		repeat (2) @(posedge ofc);
		repeat (40) @(posedge clk);
		check(out_sample, 32'h0);
		check(32'(n_ov - snap), 32'h0);
		$display("power-down done");
		print_verdict();
	end
endmodule
